// File: logic/ulpc_pkg.sv
// Purpose: Shared constants and types for the PHY-side ULPI pin control block
// Assumes: Single clock domain; all pin inputs already synchronous to clock
// Notes: Struct carriers group the link pins and the user-side byte streams
package ulpc_pkg;

    // Clock rate of the logic; the interface itself runs at its own nominal rate
    localparam int CLK_PERIOD_NS = 8;
    localparam int IFACE_CLK_MHZ = 60;

    // Bus widths and idle pattern
    localparam int DATA_W = 8;
    localparam logic [7:0] IDLE_BYTE = 8'h00;

    // Reset values of the pin drivers
    localparam logic DIR_RST = 1'h1;
    localparam logic NXT_RST = 1'h0;
    localparam logic DRIVE_RST = 1'h0;
    localparam logic SUPPLY_ON_RST = 1'h0;

    // Kinds of byte that the device returns to the link
    typedef enum logic [1:0] {
        KIND_USB_DATA,
        KIND_STATUS,
        KIND_REG_READ
    } ulpc_kind_t;

    // Link control state
    typedef enum logic [2:0] {
        ST_BLOCK,
        ST_IDLE,
        ST_TX,
        ST_TURN_UP,
        ST_SEND,
        ST_LAST
    } ulpc_state_t;

    // Pins driven by the link, as seen inside the device
    typedef struct packed {
        logic [7:0] data;
        logic stp;
    } ulpc_link_in_t;

    // Pins driven by the device; each enable is low while driving
    typedef struct packed {
        logic dir;
        logic dir_oe_n;
        logic nxt;
        logic nxt_oe_n;
        logic [7:0] data;
        logic data_oe_n;
    } ulpc_link_out_t;

    // Byte offered by the device core for return to the link
    typedef struct packed {
        logic valid;
        ulpc_kind_t kind;
        logic last;
        logic [7:0] data;
    } ulpc_src_t;

    // Byte taken from the link while it transmits
    typedef struct packed {
        logic valid;
        logic cmd;
        logic [7:0] data;
    } ulpc_tx_t;

endpackage : ulpc_pkg

// File: logic/ulpc_turn.sv
// Purpose: Marks the turnaround cycle that follows every change of direction
// Assumes: dir is the registered direction pin value
// Notes: High for exactly one cycle after each edge on which dir changed
`timescale 1ns/1ps
module ulpc_turn
    import ulpc_pkg::*;
(
    input logic clock,
    input logic rst,
    input logic dir,
    output logic turn
);

    logic dir_q_r;

    // Delayed copy of the direction pin
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            dir_q_r <= DIR_RST;
        end
        else
        begin
            dir_q_r <= dir;
        end
    end

    // Bus content is meaningless while the drivers swap over
    assign turn = dir_q_r != dir;

endmodule : ulpc_turn

// File: logic/ulpc_phy_pins.sv
// Purpose: PHY-side control of the ULPI direction, pacing and stop pins
// Assumes: Link pins sampled on the rising clock edge; one clock domain
// Notes: Open-drain and tri-state pins are split into value and enable
`timescale 1ns/1ps

// Overview of operation
// - Pull supply switch low when host mode and external supply enable are set.
// - Active-low hard reset asynchronously resets all logic; power-on reset also exists.
// - Direction rests low so the device listens to the link.
// - Direction goes high to return USB data, status or read data.
// - Direction held high during power-up, reset and suspend.
// - Chip select high tri-states direction, next and data outputs.
// - Stop while direction is high aborts, except during lockout; direction drops next cycle.
// - Stop input is ignored while chip select is high.
// - Next stays low unless requesting or presenting a data byte.
// - Direction low and link sending: next requests the following byte.
// - Direction high and device sending: next marks a further valid byte.
// - Next stays low for status bytes and register read data.
// - Interface clock supplied by device; all pins synchronous to it.
// - Bus ignored for one cycle after every direction change.
// - Direction and next high mean USB data; next low means status or register read data.
module ulpc_phy_pins
    import ulpc_pkg::*;
(
    input logic clock,
    input logic rst,
    input logic hard_reset_n,
    input logic chip_select_n,
    input ulpc_link_in_t link_in,
    output ulpc_link_out_t link_out,
    input ulpc_src_t src,
    output logic src_ready,
    input logic hold_bus,
    input logic tx_ready,
    output ulpc_tx_t tx_out,
    output logic tx_end,
    output logic abort,
    output logic turnaround,
    input logic host_mode,
    input logic external_supply_enable_bit,
    output logic ext_supply_switch_low_o,
    output logic ext_supply_switch_low_oe_n
);

    ulpc_state_t state_r;
    ulpc_state_t state_nxt;
    logic dir_r;
    logic dir_nxt;
    logic nxt_r;
    logic nxt_nxt;
    logic drive_r;
    logic drive_nxt;
    logic [7:0] data_r;
    logic [7:0] data_nxt;
    logic first_r;
    logic first_nxt;
    ulpc_tx_t tx_r;
    ulpc_tx_t tx_nxt;
    logic tx_end_r;
    logic tx_end_nxt;
    logic abort_r;
    logic abort_nxt;
    logic supply_on_r;
    logic rst_all;
    logic turn;
    logic stp_ok;
    logic bus_ok;
    logic cmd_seen;

    // Either reset source clears everything without waiting for the clock
    assign rst_all = rst | ~hard_reset_n;

    ulpc_turn u_turn (
        .clock(clock),
        .rst(rst_all),
        .dir(dir_r),
        .turn(turn)
    );

    // Qualified link inputs
    assign stp_ok = link_in.stp & ~chip_select_n;
    assign bus_ok = ~turn & ~chip_select_n;
    assign cmd_seen = bus_ok & (link_in.data != IDLE_BYTE);
    assign turnaround = turn;

    // Core may hand over a byte only while the bus is ours and not aborted
    assign src_ready = (state_r == ST_SEND) & ~stp_ok;

    // Next-state and pin decisions
    always_comb
    begin
        state_nxt = state_r;
        dir_nxt = dir_r;
        nxt_nxt = 1'h0;
        drive_nxt = drive_r;
        data_nxt = data_r;
        first_nxt = first_r;
        tx_nxt = '0;
        tx_end_nxt = 1'h0;
        abort_nxt = 1'h0;
        unique case (state_r)
            ST_BLOCK:
            begin
                // Link locked out until power-up or suspend ends
                if (!hold_bus)
                begin
                    state_nxt = ST_IDLE;
                    dir_nxt = 1'h0;
                    drive_nxt = 1'h0;
                end
            end
            ST_IDLE:
            begin
                if (hold_bus)
                begin
                    state_nxt = ST_BLOCK;
                    dir_nxt = 1'h1;
                    drive_nxt = 1'h0;
                end
                else if (cmd_seen)
                begin
                    // Link holds its command byte until next accepts it
                    state_nxt = ST_TX;
                    nxt_nxt = tx_ready;
                    first_nxt = 1'h1;
                end
                else if (src.valid)
                begin
                    state_nxt = ST_TURN_UP;
                    dir_nxt = 1'h1;
                end
            end
            ST_TX:
            begin
                if (stp_ok)
                begin
                    // Byte beside stop is not payload
                    state_nxt = ST_IDLE;
                    tx_end_nxt = 1'h1;
                end
                else
                begin
                    if (nxt_r)
                    begin
                        tx_nxt.valid = 1'h1;
                        tx_nxt.cmd = first_r;
                        tx_nxt.data = link_in.data;
                        first_nxt = 1'h0;
                    end
                    nxt_nxt = tx_ready;
                end
            end
            ST_TURN_UP:
            begin
                // Drivers stay off through the turnaround cycle
                if (stp_ok)
                begin
                    state_nxt = ST_IDLE;
                    dir_nxt = 1'h0;
                    abort_nxt = 1'h1;
                end
                else
                begin
                    state_nxt = ST_SEND;
                end
            end
            ST_SEND:
            begin
                if (stp_ok)
                begin
                    state_nxt = ST_IDLE;
                    dir_nxt = 1'h0;
                    drive_nxt = 1'h0;
                    abort_nxt = 1'h1;
                end
                else if (src.valid)
                begin
                    drive_nxt = 1'h1;
                    data_nxt = src.data;
                    nxt_nxt = src.kind == KIND_USB_DATA;
                    if (src.last)
                    begin
                        state_nxt = ST_LAST;
                    end
                end
            end
            ST_LAST:
            begin
                // Final byte is on the bus now; release afterwards
                state_nxt = ST_IDLE;
                dir_nxt = 1'h0;
                drive_nxt = 1'h0;
                abort_nxt = stp_ok;
            end
        endcase
    end

    // Control and pin registers; reset leaves the link locked out
    always_ff @(posedge clock or posedge rst_all)
    begin
        if (rst_all)
        begin
            state_r <= ST_BLOCK;
            dir_r <= DIR_RST;
            nxt_r <= NXT_RST;
            drive_r <= DRIVE_RST;
            data_r <= IDLE_BYTE;
            first_r <= 1'h0;
        end
        else
        begin
            state_r <= state_nxt;
            dir_r <= dir_nxt;
            nxt_r <= nxt_nxt;
            drive_r <= drive_nxt;
            data_r <= data_nxt;
            first_r <= first_nxt;
        end
    end

    // Strobes towards the device core
    always_ff @(posedge clock or posedge rst_all)
    begin
        if (rst_all)
        begin
            tx_r <= '0;
            tx_end_r <= 1'h0;
            abort_r <= 1'h0;
        end
        else
        begin
            tx_r <= tx_nxt;
            tx_end_r <= tx_end_nxt;
            abort_r <= abort_nxt;
        end
    end

    assign tx_out = tx_r;
    assign tx_end = tx_end_r;
    assign abort = abort_r;

    // Supply switch request; registered to keep the pin glitch free
    always_ff @(posedge clock or posedge rst_all)
    begin
        if (rst_all)
        begin
            supply_on_r <= SUPPLY_ON_RST;
        end
        else
        begin
            supply_on_r <= host_mode & external_supply_enable_bit;
        end
    end

    // Open drain: only ever pulls low, the pull-up gives the high
    assign ext_supply_switch_low_o = 1'h0;
    assign ext_supply_switch_low_oe_n = ~supply_on_r;

    // Pin drivers; chip select overrides every enable
    assign link_out.dir = dir_r;
    assign link_out.dir_oe_n = chip_select_n;
    assign link_out.nxt = nxt_r;
    assign link_out.nxt_oe_n = chip_select_n;
    assign link_out.data = data_r;
    assign link_out.data_oe_n = ~(drive_r & dir_r) | chip_select_n;

endmodule : ulpc_phy_pins

// File: dv/ulpc_phy_pins_assertions.sv
// Purpose: Port-level checks of the ULPI pin control block
// Assumes: One clock; either reset disables the checks, except AST_HARD_RESET, which only rst disables
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
module ulpc_phy_pins_chk
    import ulpc_pkg::*;
(
    input logic clock,
    input logic rst,
    input logic hard_reset_n,
    input logic chip_select_n,
    input ulpc_link_in_t link_in,
    input ulpc_link_out_t link_out,
    input ulpc_src_t src,
    input logic src_ready,
    input logic hold_bus,
    input logic tx_ready,
    input ulpc_tx_t tx_out,
    input logic tx_end,
    input logic abort,
    input logic turnaround,
    input logic host_mode,
    input logic external_supply_enable_bit,
    input logic ext_supply_switch_low_o,
    input logic ext_supply_switch_low_oe_n
);
    // All checks share the one clock
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst || !hard_reset_n);
    // A returned byte taken with no stop, split by kind
    sequence s_usb;
        src.valid && src_ready && !link_in.stp && !chip_select_n && src.kind == KIND_USB_DATA;
    endsequence
    sequence s_other;
        src.valid && src_ready && !link_in.stp && !chip_select_n && src.kind != KIND_USB_DATA;
    endsequence
    AST_SUPPLY_ON: assert property (
        host_mode && external_supply_enable_bit |=> !ext_supply_switch_low_oe_n)
        else $error("supply switch not pulled low");
    AST_HARD_RESET: assert property (disable iff (rst) !hard_reset_n |->
        link_out.dir && link_out.data_oe_n && !link_out.nxt) else $error("hard reset ignored");
    AST_CS_TRISTATE: assert property (chip_select_n |->
        link_out.dir_oe_n && link_out.nxt_oe_n && link_out.data_oe_n) else $error("pins driven");
    AST_ABORT_DROP: assert property (abort |-> !link_out.dir &&
        $past(link_in.stp) && $past(link_out.dir)) else $error("abort without stop");
    AST_NXT_USB: assert property (s_usb |=> link_out.nxt && !link_out.data_oe_n)
        else $error("usb byte without next");
    AST_NXT_STATUS: assert property (s_other |=> !link_out.nxt)
        else $error("next high on status byte");
    AST_TX_PACED: assert property (tx_out.valid |->
        $past(link_out.nxt) && !$past(link_out.dir)) else $error("byte taken unpaced");
    AST_TURN: assert property ($changed(link_out.dir) |->
        turnaround && link_out.data_oe_n) else $error("turnaround missing");
endmodule : ulpc_phy_pins_chk

bind ulpc_phy_pins ulpc_phy_pins_chk u_ulpc_phy_pins_chk (.clock(clock), .rst(rst),
    .hard_reset_n(hard_reset_n), .chip_select_n(chip_select_n), .link_in(link_in),
    .link_out(link_out), .src(src), .src_ready(src_ready), .hold_bus(hold_bus),
    .tx_ready(tx_ready), .tx_out(tx_out), .tx_end(tx_end), .abort(abort),
    .turnaround(turnaround), .host_mode(host_mode),
    .external_supply_enable_bit(external_supply_enable_bit),
    .ext_supply_switch_low_o(ext_supply_switch_low_o),
    .ext_supply_switch_low_oe_n(ext_supply_switch_low_oe_n));

// File: dv/ulpc_link_model.sv
// Purpose: Behavioural link that sends packets and stops transfers
// Assumes: Drives its pins at the falling clock edge
// Notes: Bus release is resolved by the bench at the pull-down level
`timescale 1ns/1ps
module ulpc_link_model
(
    input logic clock,
    input logic dir,
    input logic nxt,
    output logic [7:0] data,
    output logic stp
);
    // Idle bus is all zero; only synchronous mode is ever used
    initial
    begin
        data = 8'h00;
        stp = 1'b0;
    end
    // Command, n payload bytes paced by next, then stop
    task automatic send(input logic [7:0] cmd, input int n);
        int k;
        repeat (2) @(negedge clock);
        data = cmd;
        for (int i = 0; i <= n; i++)
        begin
            k = 0;
            while (!nxt && k < 40)
            begin
                @(negedge clock);
                k++;
            end
            @(negedge clock);
            data = (i < n) ? 8'hA0 + 8'(i) : 8'h00;
            stp = (i == n);
        end
        @(negedge clock);
        stp = 1'b0;
    endtask : send
    // One-cycle stop while the device owns the bus
    task automatic stop_pulse();
        @(negedge clock);
        stp = dir;
        @(negedge clock);
        stp = 1'b0;
    endtask : stop_pulse
endmodule : ulpc_link_model

// File: dv/ulpi_phy_pin_control_tb.sv
// Purpose: Self-checking bench for the ULPI pin control block
// Assumes: Inputs change at the falling edge; link model on the pins
// Notes: Pin traffic is counted at the rising edge
`timescale 1ns/1ps
module ulpi_phy_pin_control_tb;
    import ulpc_pkg::*;
    logic clock, rst, hard_reset_n, chip_select_n, hold_bus, tx_ready, host_mode, supply_en;
    logic src_ready, tx_end, abort, turnaround, sw_o, sw_oe_n, lk_stp, lk_dir, lk_nxt;
    logic [7:0] lk_data;
    logic [31:0] txw, rxw;
    ulpc_link_in_t link_in;
    ulpc_link_out_t link_out;
    ulpc_src_t src;
    ulpc_tx_t tx_out;
    int bad_count, samples_checked, cyc, txc, cmdc, endc, abc, drc, nxc, trc;
    // Pull-down holds the bus low when nobody drives it
    assign link_in = {(!link_out.data_oe_n ? link_out.data : (link_out.dir ? 8'h00 : lk_data)),
        lk_stp};
    // A tri-stated pin has no pull, so the link sees the inverse of the last value
    assign lk_dir = link_out.dir_oe_n ? !link_out.dir : link_out.dir;
    assign lk_nxt = link_out.nxt_oe_n ? !link_out.nxt : link_out.nxt;
    ulpc_phy_pins u_ulpc_phy_pins (.clock(clock), .rst(rst), .hard_reset_n(hard_reset_n),
        .chip_select_n(chip_select_n), .link_in(link_in), .link_out(link_out), .src(src),
        .src_ready(src_ready), .hold_bus(hold_bus), .tx_ready(tx_ready), .tx_out(tx_out),
        .tx_end(tx_end), .abort(abort), .turnaround(turnaround), .host_mode(host_mode),
        .external_supply_enable_bit(supply_en), .ext_supply_switch_low_o(sw_o),
        .ext_supply_switch_low_oe_n(sw_oe_n));
    ulpc_link_model u_ulpc_link_model (.clock(clock), .dir(lk_dir), .nxt(lk_nxt),
        .data(lk_data), .stp(lk_stp));
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Count pin traffic; the cycle ceiling cuts a hang short
    always @(posedge clock)
    begin
        cyc++;
        txc += (tx_out.valid === 1'b1);
        cmdc += (tx_out.valid === 1'b1 && tx_out.cmd === 1'b1);
        endc += (tx_end === 1'b1);
        abc += (abort === 1'b1);
        drc += (link_out.data_oe_n === 1'b0);
        nxc += (link_out.data_oe_n === 1'b0 && link_out.nxt === 1'b1);
        trc += (turnaround === 1'b1);
        if (tx_out.valid === 1'b1)
        begin
            txw = {txw[23:0], tx_out.data};
        end
        if (link_out.data_oe_n === 1'b0)
        begin
            rxw = {rxw[23:0], link_out.data};
        end
        if (cyc == 3000)
        begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask : wt
    task automatic clr();
        @(negedge clock);
        {txc, cmdc, endc, abc, drc, nxc, trc} = '0;
        {txw, rxw} = '0;
    endtask : clr
    // Offer n bytes of one kind; each waits for the ready handshake
    task automatic give(input ulpc_kind_t kind, input int n);
        int k;
        for (int i = 0; i < n; i++)
        begin
            src = {1'b1, kind, i == n - 1, 8'h5A + 8'(i)};
            k = 0;
            while (src_ready !== 1'b1 && k < 40)
            begin
                @(negedge clock);
                k++;
            end
            @(negedge clock);
        end
        src.valid = 1'b0;
    endtask : give
    task automatic t_reset();
        chk(link_out.dir, 1'b1);
        chk(sw_oe_n, 1'b1);
        hold_bus = 1'b0;
        wt(3);
        chk(link_out.dir, 1'b0);
        hard_reset_n = 1'b0;
        #1 chk(link_out.dir, 1'b1);
        wt(2);
        hard_reset_n = 1'b1;
        wt(3);
        chk(link_out.dir, 1'b0);
    endtask : t_reset
    task automatic t_tx();
        clr();
        u_ulpc_link_model.send(8'h41, 2);
        wt(2);
        chk(txc, 3);
        chk(cmdc, 1);
        chk(txw, 32'h0041A0A1);
        chk(endc, 1);
    endtask : t_tx
    task automatic t_ret(input ulpc_kind_t kind, input int n, input int nx,
        input logic [31:0] ew);
        clr();
        give(kind, n);
        wt(4);
        chk(drc, n);
        chk(rxw, ew);
        chk(nxc, nx);
        chk(trc, 2);
        chk(link_out.dir, 1'b0);
    endtask : t_ret
    task automatic t_abort();
        src = {1'b1, KIND_USB_DATA, 1'b0, 8'h33};
        wt(3);
        u_ulpc_link_model.stop_pulse();
        chk(link_out.dir, 1'b0);
        chk(abort, 1'b1);
        src.valid = 1'b0;
    endtask : t_abort
    task automatic t_cs();
        clr();
        chip_select_n = 1'b1;
        #1 chk({link_out.dir_oe_n, link_out.nxt_oe_n, link_out.data_oe_n}, 8'h07);
        u_ulpc_link_model.send(8'h41, 0);
        wt(2);
        chk(txc + endc + abc, 0);
        chip_select_n = 1'b0;
    endtask : t_cs
    task automatic t_sup();
        for (int i = 0; i < 4; i++)
        begin
            {host_mode, supply_en} = 2'(i);
            wt(2);
            chk({sw_o, sw_oe_n}, {7'h00, !(host_mode && supply_en)});
        end
        // Overcurrent reported: the link drops the enable while still host
        supply_en = 1'b0;
        wt(2);
        chk(sw_oe_n, 1'b1);
    endtask : t_sup
    // Suspend locks the link out; the clock keeps running throughout
    task automatic t_susp();
        hold_bus = 1'b1;
        wt(2);
        chk(link_out.dir, 1'b1);
        chk(link_out.data_oe_n, 1'b1);
        hold_bus = 1'b0;
        wt(3);
        chk(link_out.dir, 1'b0);
    endtask : t_susp
    initial
    begin
        rst = 1'b1;
        hard_reset_n = 1'b1;
        chip_select_n = 1'b0;
        hold_bus = 1'b1;
        tx_ready = 1'b1;
        {host_mode, supply_en} = 2'h0;
        src = '0;
        repeat (16) @(negedge clock);
        rst = 1'b0;
        wt(2);
        t_reset();
        t_tx();
        t_ret(KIND_USB_DATA, 3, 3, 32'h005A5B5C);
        t_ret(KIND_STATUS, 1, 0, 32'h0000005A);
        t_ret(KIND_REG_READ, 1, 0, 32'h0000005A);
        t_abort();
        wt(4);
        t_cs();
        t_sup();
        t_susp();
        stop_test();
    end
endmodule : ulpi_phy_pin_control_tb
